/* File: src/ecgim_top.sv */
// Overview of operation
// - Each enable register gates its own output: OR of enabled status terms.
// - Enable bits 23..20 and 11..8 map one-to-one to status bits.
// - After reset all enable bits are zero, both outputs idle.
// - Both interrupt outputs are active low.
// - Primary driver kind at bits 1..0: tristate, push-pull, open-drain, pullup.
// - Secondary register has its own driver kind field, reset 11.
// - Fill flag when unread records reach threshold plus one, reset 01111.
// - Recovery clear bit 0: flag follows recovery, then held until status read.
// - Recovery clear bit 1: read clears flag, sets again only on re-entry.
// - Beat flag clears on status read, interval read or next data cycle.
// - Tick clears on status read, or self-clears after quarter data cycle.
// - Tick issued every 1st, 2nd, 4th or 16th sample instant.
// - Dynamic-mode writes touch nothing but the recovery settings.
// - Fill flag stays set until enough records are read.
// - Beat flag raised on each detected heartbeat event.
// - Tick flag raised on decimated base-rate sampling instant.
`timescale 1ns/10ps
module ecgim_top (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic REG_RD_DONE,
  input wire logic [6:0] REG_ADDR,
  input wire logic [23:0] REG_WDATA,
  output logic [23:0] REG_RDATA,
  // Status sources
  input wire logic [5:0] FIFO_UNREAD,
  input wire logic FIFO_OVERRUN_FLAG,
  input wire logic QUICK_RECOVERY_ACTIVE,
  input wire logic LEAD_DETACH_FLAG,
  input wire logic LEAD_ATTACH_FLAG,
  input wire logic LOCK_LOSS_FLAG,
  input wire logic BEAT_DETECT,
  input wire logic SAMPLE_INSTANT,
  // Primary interrupt pin
  output logic IRQ_OUT_PRIMARY_N_O,
  output logic IRQ_OUT_PRIMARY_OE,
  output logic IRQ_OUT_PRIMARY_PULLUP,
  // Secondary interrupt pin
  output logic IRQ_OUT_SECONDARY_N_O,
  output logic IRQ_OUT_SECONDARY_OE,
  output logic IRQ_OUT_SECONDARY_PULLUP,
  // Dynamic recovery settings
  output logic [1:0] QUICK_RECOVERY_MODE,
  output logic [5:0] QUICK_RECOVERY_THRESHOLD
);

  // ==========================================================
  // Registers
  logic [23:0] pri_en_ff;
  logic [23:0] sec_en_ff;
  logic [23:0] mngr_ff;
  logic [23:0] dyn_ff;
  logic fill_flag_ff;
  logic qrec_active_d_ff;
  logic [3:0] decim_ff;
  logic [19:0] period_run_ff;
  logic [19:0] period_ff;
  logic [19:0] tick_age_ff;
  logic quick_recovery_flag;
  logic beat_event_flag;
  logic sync_tick_flag;

  // ==========================================================
  // Decode
  wire wr_pri = REG_WR && (REG_ADDR == ecgim_pkg::ADDR_PRI_EN);
  wire wr_sec = REG_WR && (REG_ADDR == ecgim_pkg::ADDR_SEC_EN);
  wire wr_mngr = REG_WR && (REG_ADDR == ecgim_pkg::ADDR_MNGR);
  wire wr_dyn = REG_WR && (REG_ADDR == ecgim_pkg::ADDR_DYN);
  wire status_read = REG_RD_DONE &&
    (REG_ADDR == ecgim_pkg::ADDR_STATUS);
  wire interval_read = REG_RD_DONE &&
    (REG_ADDR == ecgim_pkg::ADDR_BEAT_INTERVAL);

  // Management fields
  wire [4:0] fifo_fill_threshold = mngr_ff[ecgim_pkg::THR_LSB +: 5];
  wire quick_recovery_clear_mode = mngr_ff[ecgim_pkg::QCLR_BIT];
  wire [1:0] beat_event_clear_mode = mngr_ff[ecgim_pkg::BCLR_LSB +: 2];
  wire tick_clear_mode = mngr_ff[ecgim_pkg::TCLR_BIT];
  wire [1:0] tick_rate_select = mngr_ff[ecgim_pkg::RATE_LSB +: 2];

  // ==========================================================
  // Register writes, only masked bits are stored
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pri_en_ff <= ecgim_pkg::EN_RST;
      sec_en_ff <= ecgim_pkg::EN_RST;
      mngr_ff <= ecgim_pkg::MNGR_RST;
      dyn_ff <= ecgim_pkg::DYN_RST;
    end else begin
      if (wr_pri) pri_en_ff <= REG_WDATA & ecgim_pkg::EN_MASK;
      if (wr_sec) sec_en_ff <= REG_WDATA & ecgim_pkg::EN_MASK;
      if (wr_mngr) mngr_ff <= REG_WDATA & ecgim_pkg::MNGR_MASK;
      if (wr_dyn) dyn_ff <= REG_WDATA & ecgim_pkg::DYN_MASK;
    end
  end

  // ==========================================================
  // Fill flag is a pure level, so it drops as soon as enough records are read
  // threshold compare
  wire fill_level = FIFO_UNREAD >= ({1'b0, fifo_fill_threshold} + 6'h01);

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) fill_flag_ff <= 1'b0;
    else fill_flag_ff <= fill_level;
  end

  // ==========================================================
  // Quick recovery flag
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) qrec_active_d_ff <= 1'b0;
    else qrec_active_d_ff <= QUICK_RECOVERY_ACTIVE;
  end

  wire qrec_entry = QUICK_RECOVERY_ACTIVE && !qrec_active_d_ff;
  // entry-only set in clear mode 1
  wire qrec_set = quick_recovery_clear_mode ? qrec_entry :
    QUICK_RECOVERY_ACTIVE;

  ecgim_flag u_qrec_flag (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .set(qrec_set),
    .clr(status_read),
    .flag_ff(quick_recovery_flag)
  );

  // ==========================================================
  // Beat flag, self-clear waits for the next data-rate instant
  // clear selection
  wire beat_clr =
    (beat_event_clear_mode == ecgim_pkg::BCLR_INTERVAL) ? interval_read :
    (beat_event_clear_mode == ecgim_pkg::BCLR_SELF) ? SAMPLE_INSTANT :
    status_read;

  ecgim_flag u_beat_flag (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .set(BEAT_DETECT),
    .clr(beat_clr),
    .flag_ff(beat_event_flag)
  );

  // ==========================================================
  // Tick decimation and data-rate period measurement
  wire [3:0] rate_mask =
    (tick_rate_select == 2'h3) ? ecgim_pkg::RATE_MASK_16 :
    (tick_rate_select == 2'h2) ? ecgim_pkg::RATE_MASK_4 :
    (tick_rate_select == 2'h1) ? ecgim_pkg::RATE_MASK_2 :
    ecgim_pkg::RATE_MASK_1;
  wire tick_hit = SAMPLE_INSTANT && ((decim_ff & rate_mask) == 4'h0);
  wire [19:0] quarter_raw = period_ff >> ecgim_pkg::QUARTER_SHIFT;
  // Before the first period is known the pulse lasts one cycle
  wire [19:0] quarter = (quarter_raw == 20'h0) ? ecgim_pkg::PERIOD_ONE :
    quarter_raw;
  wire tick_clr = tick_clear_mode ? (tick_age_ff >= quarter) :
    status_read;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      decim_ff <= 4'h0;
      period_run_ff <= 20'h0;
      period_ff <= 20'h0;
    end else if (SAMPLE_INSTANT) begin
      decim_ff <= decim_ff + 4'h1;
      period_run_ff <= ecgim_pkg::PERIOD_ONE;
      period_ff <= period_run_ff;
    end else if (period_run_ff != ecgim_pkg::PERIOD_MAX) begin
      period_run_ff <= period_run_ff + 20'h1;
    end
  end

  // Age of the tick flag, saturating
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) tick_age_ff <= 20'h0;
    else if (tick_hit) tick_age_ff <= ecgim_pkg::PERIOD_ONE;
    else if (sync_tick_flag && tick_age_ff != ecgim_pkg::PERIOD_MAX)
      tick_age_ff <= tick_age_ff + 20'h1;
  end

  ecgim_flag u_tick_flag (
    .clk(CLK_SYS),
    .resetn(RESETN),
    .set(tick_hit),
    .clr(tick_clr),
    .flag_ff(sync_tick_flag)
  );

  // ==========================================================
  // Status vector and interrupt OR terms
  logic [23:0] status_vec;
  always_comb begin
    status_vec = 24'h0;
    status_vec[ecgim_pkg::FILL_BIT] = fill_flag_ff;
    status_vec[ecgim_pkg::OVERRUN_BIT] = FIFO_OVERRUN_FLAG;
    status_vec[ecgim_pkg::QREC_BIT] = quick_recovery_flag;
    status_vec[ecgim_pkg::DETACH_BIT] = LEAD_DETACH_FLAG;
    status_vec[ecgim_pkg::ATTACH_BIT] = LEAD_ATTACH_FLAG;
    status_vec[ecgim_pkg::BEAT_BIT] = beat_event_flag;
    status_vec[ecgim_pkg::TICK_BIT] = sync_tick_flag;
    status_vec[ecgim_pkg::LOCK_BIT] = LOCK_LOSS_FLAG;
  end

  wire pri_act = |(status_vec & pri_en_ff & ecgim_pkg::EN_FLAG_MASK);
  wire sec_act = |(status_vec & sec_en_ff & ecgim_pkg::EN_FLAG_MASK);
  wire [1:0] pri_kind = pri_en_ff[ecgim_pkg::KIND_LSB +: 2];
  wire [1:0] sec_kind = sec_en_ff[ecgim_pkg::KIND_LSB +: 2];

  // primary and secondary driver kind, low when active
  wire nxt_pri_o = (pri_kind == ecgim_pkg::KIND_PUSH_PULL) ? !pri_act :
    (pri_kind == ecgim_pkg::KIND_TRISTATE);
  wire nxt_pri_oe = (pri_kind == ecgim_pkg::KIND_PUSH_PULL) ||
    ((pri_kind != ecgim_pkg::KIND_TRISTATE) && pri_act);
  wire nxt_sec_o = (sec_kind == ecgim_pkg::KIND_PUSH_PULL) ? !sec_act :
    (sec_kind == ecgim_pkg::KIND_TRISTATE);
  wire nxt_sec_oe = (sec_kind == ecgim_pkg::KIND_PUSH_PULL) ||
    ((sec_kind != ecgim_pkg::KIND_TRISTATE) && sec_act);

  // ==========================================================
  // registered pin stage
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      IRQ_OUT_PRIMARY_N_O <= 1'b1;
      IRQ_OUT_PRIMARY_OE <= 1'b0;
      IRQ_OUT_PRIMARY_PULLUP <= 1'b1;
      IRQ_OUT_SECONDARY_N_O <= 1'b1;
      IRQ_OUT_SECONDARY_OE <= 1'b0;
      IRQ_OUT_SECONDARY_PULLUP <= 1'b1;
    end else begin
      IRQ_OUT_PRIMARY_N_O <= nxt_pri_o;
      IRQ_OUT_PRIMARY_OE <= nxt_pri_oe;
      IRQ_OUT_PRIMARY_PULLUP <= pri_kind == ecgim_pkg::KIND_OPEN_DRAIN_PU;
      IRQ_OUT_SECONDARY_N_O <= nxt_sec_o;
      IRQ_OUT_SECONDARY_OE <= nxt_sec_oe;
      IRQ_OUT_SECONDARY_PULLUP <= sec_kind == ecgim_pkg::KIND_OPEN_DRAIN_PU;
    end
  end

  // ==========================================================
  // Read data, registered one cycle after the read strobe
  wire [23:0] nxt_rdata =
    (REG_ADDR == ecgim_pkg::ADDR_STATUS) ? status_vec :
    (REG_ADDR == ecgim_pkg::ADDR_PRI_EN) ? pri_en_ff :
    (REG_ADDR == ecgim_pkg::ADDR_SEC_EN) ? sec_en_ff :
    (REG_ADDR == ecgim_pkg::ADDR_MNGR) ? mngr_ff :
    (REG_ADDR == ecgim_pkg::ADDR_DYN) ? dyn_ff : 24'h0;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 24'h0;
      QUICK_RECOVERY_MODE <= 2'h0;
      QUICK_RECOVERY_THRESHOLD <= 6'h0;
    end else begin
      if (REG_RD) REG_RDATA <= nxt_rdata;
      QUICK_RECOVERY_MODE <= dyn_ff[ecgim_pkg::DYN_MODE_LSB +: 2];
      QUICK_RECOVERY_THRESHOLD <= dyn_ff[ecgim_pkg::DYN_TH_LSB +: 6];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  pri_or_term_a: assert property (
    (pri_kind == ecgim_pkg::KIND_PUSH_PULL) |=>
      (IRQ_OUT_PRIMARY_N_O == !$past(pri_act)))
    else $error("primary level does not follow enabled OR");
  masked_term_a: assert property (
    (pri_en_ff[ecgim_pkg::BEAT_BIT] == 1'b0) |-> !(pri_act &&
      ((status_vec & pri_en_ff & ecgim_pkg::EN_FLAG_MASK) ==
       (24'h1 << ecgim_pkg::BEAT_BIT))))
    else $error("disabled beat term drives primary");
  reset_quiet_a: assert property (
    $rose(RESETN) |-> (pri_en_ff[23:2] == 22'h0) && !sec_act)
    else $error("enables not zero after reset");
  od_low_a: assert property (
    (pri_kind == ecgim_pkg::KIND_OPEN_DRAIN && pri_act) |=>
      (IRQ_OUT_PRIMARY_OE && !IRQ_OUT_PRIMARY_N_O))
    else $error("open drain not pulling low");
  tristate_off_a: assert property (
    (pri_kind == ecgim_pkg::KIND_TRISTATE) |=> !IRQ_OUT_PRIMARY_OE)
    else $error("tristate primary is driven");
  sec_pullup_a: assert property (
    (sec_kind == ecgim_pkg::KIND_OPEN_DRAIN_PU) |=>
      IRQ_OUT_SECONDARY_PULLUP)
    else $error("secondary pullup missing");
  fill_level_a: assert property (
    (FIFO_UNREAD > {1'b0, fifo_fill_threshold}) |=> fill_flag_ff)
    else $error("fill flag missing at threshold");
  qrec_hold_a: assert property (
    (!quick_recovery_clear_mode && quick_recovery_flag && !status_read)
      |=> quick_recovery_flag)
    else $error("recovery flag dropped without read");
  qrec_rearm_a: assert property (
    (quick_recovery_clear_mode && status_read && qrec_active_d_ff &&
     QUICK_RECOVERY_ACTIVE) ##1 QUICK_RECOVERY_ACTIVE |=>
      !quick_recovery_flag)
    else $error("recovery flag set again without re-entry");
  beat_self_a: assert property (
    (beat_event_clear_mode == ecgim_pkg::BCLR_SELF && SAMPLE_INSTANT &&
     !BEAT_DETECT) |=> !beat_event_flag)
    else $error("beat flag not self cleared");
  tick_rate_a: assert property (
    (SAMPLE_INSTANT && tick_rate_select == 2'h1 && decim_ff[0])
      |=> $stable(tick_age_ff) || !sync_tick_flag || tick_age_ff != 20'h1)
    else $error("tick issued on odd instant");
  dyn_isolated_a: assert property (
    (wr_dyn) |=> $stable(mngr_ff) && $stable(pri_en_ff))
    else $error("dynamic write disturbed other state");

  pri_fire_c: cover property (pri_act ##1 !IRQ_OUT_PRIMARY_N_O);
  beat_read_c: cover property (beat_event_flag ##1 interval_read);
  tick_self_c: cover property (tick_hit ##[1:50] !sync_tick_flag);
  qrec_cycle_c: cover property (qrec_entry ##[1:50] status_read);

endmodule : ecgim_top

/* File: src/ecgim_pkg.sv */
package ecgim_pkg;

  // ==========================================================
  // Register addresses (7-bit register port)
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_PRI_EN = 7'h02;
  localparam logic [6:0] ADDR_SEC_EN = 7'h03;
  localparam logic [6:0] ADDR_MNGR = 7'h04;
  localparam logic [6:0] ADDR_DYN = 7'h05;
  localparam logic [6:0] ADDR_BEAT_INTERVAL = 7'h20;

  // ==========================================================
  // Writable bit masks, reserved bits read as zero
  localparam logic [23:0] EN_MASK = 24'hf00f03;
  localparam logic [23:0] EN_FLAG_MASK = 24'hf00f00;
  localparam logic [23:0] MNGR_MASK = 24'hf80077;
  localparam logic [23:0] DYN_MASK = 24'hff0000;

  // ==========================================================
  // Reset values
  localparam logic [23:0] EN_RST = 24'h000003;
  localparam logic [23:0] MNGR_RST = 24'h780004;
  localparam logic [23:0] DYN_RST = 24'h3f0000;

  // ==========================================================
  // Status bit positions
  localparam int FILL_BIT = 23;
  localparam int OVERRUN_BIT = 22;
  localparam int QREC_BIT = 21;
  localparam int DETACH_BIT = 20;
  localparam int ATTACH_BIT = 11;
  localparam int BEAT_BIT = 10;
  localparam int TICK_BIT = 9;
  localparam int LOCK_BIT = 8;

  // ==========================================================
  // Field positions
  localparam int KIND_LSB = 0;
  localparam int THR_LSB = 19;
  localparam int QCLR_BIT = 6;
  localparam int BCLR_LSB = 4;
  localparam int TCLR_BIT = 2;
  localparam int RATE_LSB = 0;
  localparam int DYN_MODE_LSB = 22;
  localparam int DYN_TH_LSB = 16;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    KIND_TRISTATE = 2'h0,
    KIND_PUSH_PULL = 2'h1,
    KIND_OPEN_DRAIN = 2'h2,
    KIND_OPEN_DRAIN_PU = 2'h3
  } ecgim_kind_t;

  localparam logic [1:0] BCLR_STATUS = 2'h0;
  localparam logic [1:0] BCLR_INTERVAL = 2'h1;
  localparam logic [1:0] BCLR_SELF = 2'h2;

  // Tick decimation masks for rate codes 00..11
  localparam logic [3:0] RATE_MASK_1 = 4'h0;
  localparam logic [3:0] RATE_MASK_2 = 4'h1;
  localparam logic [3:0] RATE_MASK_4 = 4'h3;
  localparam logic [3:0] RATE_MASK_16 = 4'hf;

  // Data-rate period measurement width and quarter shift
  localparam int PERIOD_W = 20;
  localparam int QUARTER_SHIFT = 2;
  localparam logic [19:0] PERIOD_MAX = 20'hfffff;
  localparam logic [19:0] PERIOD_ONE = 20'h00001;

endpackage : ecgim_pkg

/* File: src/ecgim_flag.sv */
`timescale 1ns/10ps
module ecgim_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Event and clear
  input wire logic set,
  input wire logic clr,
  // Sticky flag
  output logic flag_ff
);

  // ==========================================================
  // Sticky flag, set wins so an event is never lost on a clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_ff <= 1'b0;
    end else if (set) begin
      flag_ff <= 1'b1;
    end else if (clr) begin
      flag_ff <= 1'b0;
    end
  end

endmodule : ecgim_flag

/* File: testbench/ecgim_host.sv */
`timescale 1ns/10ps
// ==========================================
// Host side of the register port
module ecgim_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic wr,
  output logic rd,
  output logic rd_done,
  output logic [6:0] addr,
  output logic [23:0] wdata,
  input wire logic [23:0] rdata
);
  // Idle port; address parked off the map so no strobe aliases a register
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    rd_done = 1'b0;
    addr = 7'h7f;
    wdata = 24'h0;
  end

  // Requests start at a falling edge and hold across one rising edge
  task automatic write(input logic [6:0] a, input logic [23:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = 7'h7f;
    wdata = ~d;
  endtask : write

  // Data is taken one edge after the strobe, as the port answers
  task automatic read(input logic [6:0] a, output logic [23:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    d = rdata;
    rd = 1'b0;
    addr = 7'h7f;
  endtask : read

  // End of a serial read frame, the point where read-clear flags drop
  task automatic done(input logic [6:0] a);
    @(negedge clk);
    addr = a;
    rd_done = 1'b1;
    @(negedge clk);
    rd_done = 1'b0;
    addr = 7'h7f;
  endtask : done
endmodule : ecgim_host

/* File: testbench/ecgim_top_tb.sv */
`timescale 1ns/10ps
module ecgim_top_tb;
  // ==========================================
  // Signals
  localparam logic [6:0] ST = ecgim_pkg::ADDR_STATUS;
  localparam logic [6:0] PE = ecgim_pkg::ADDR_PRI_EN;
  localparam logic [6:0] SE = ecgim_pkg::ADDR_SEC_EN;
  localparam logic [6:0] MG = ecgim_pkg::ADDR_MNGR;
  localparam logic [6:0] DY = ecgim_pkg::ADDR_DYN;
  logic clk_sys, resetn, wr, rd, rdd;
  logic [6:0] addr;
  logic [23:0] wd, rdat, v;
  logic [5:0] fifo;
  logic [3:0] lv;
  logic qrec, beat, inst, pn, poe, ppu, sn, soe, spu;
  logic [1:0] qm;
  logic [5:0] qt;
  int n_mismatch = 0;
  int cmp_count = 0;
  int bits [4] = '{8, 11, 20, 22};

  // ==========================================
  // Design and host
  ecgim_top uut (.CLK_SYS(clk_sys), .RESETN(resetn), .REG_WR(wr),
    .REG_RD(rd), .REG_RD_DONE(rdd), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_RDATA(rdat), .FIFO_UNREAD(fifo), .FIFO_OVERRUN_FLAG(lv[3]),
    .QUICK_RECOVERY_ACTIVE(qrec), .LEAD_DETACH_FLAG(lv[2]),
    .LEAD_ATTACH_FLAG(lv[1]), .LOCK_LOSS_FLAG(lv[0]),
    .BEAT_DETECT(beat), .SAMPLE_INSTANT(inst),
    .IRQ_OUT_PRIMARY_N_O(pn), .IRQ_OUT_PRIMARY_OE(poe),
    .IRQ_OUT_PRIMARY_PULLUP(ppu), .IRQ_OUT_SECONDARY_N_O(sn),
    .IRQ_OUT_SECONDARY_OE(soe), .IRQ_OUT_SECONDARY_PULLUP(spu),
    .QUICK_RECOVERY_MODE(qm), .QUICK_RECOVERY_THRESHOLD(qt));
  ecgim_host host (.clk(clk_sys), .wr(wr), .rd(rd), .rd_done(rdd),
    .addr(addr), .wdata(wd), .rdata(rdat));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================
  // Helpers
  task automatic chk(input logic [23:0] g, input logic [23:0] e,
                     input string s);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Pin model: push-pull drives always, open-drain only pulls low
  task automatic pin(input logic sec, input logic [1:0] k,
                     input logic act, input string s);
    logic [2:0] e;
    e[2] = (k == 2'h1) ? !act : (k == 2'h0);
    e[1] = (k == 2'h1) ? 1'b1 : (k[1] & act);
    e[0] = (k == 2'h3);
    chk(sec ? {21'h0, sn, soe, spu} : {21'h0, pn, poe, ppu},
        {21'h0, e}, s);
  endtask : pin

  task automatic rdchk(input logic [6:0] a, input logic [23:0] e,
                       input string s);
    host.read(a, v);
    chk(v, e, s);
  endtask : rdchk

  task automatic sbit(input int b, input logic e, input string s);
    host.read(ST, v);
    chk({23'h0, v[b]}, {23'h0, e}, s);
  endtask : sbit

  // One-cycle event pulse: beat when b is set, else sample instant
  task automatic pulse(input logic b);
    if (b) beat = 1'b1;
    else inst = 1'b1;
    @(negedge clk_sys);
    beat = 1'b0;
    inst = 1'b0;
  endtask : pulse

  // ==========================================
  // Scenarios
  task automatic t_reset;
    rdchk(PE, 24'h000003, "pri en reset");
    rdchk(SE, 24'h000003, "sec en reset");
    rdchk(MG, 24'h780004, "mngr reset");
    pin(1'b0, 2'h3, 1'b0, "pri idle");
    pin(1'b1, 2'h3, 1'b0, "sec idle");
    host.write(7'h07, 24'hffffff);
    rdchk(7'h07, 24'h0, "unmapped");
    host.write(PE, 24'hffffff);
    rdchk(PE, 24'hf00f03, "pri mask");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_map;
    for (int i = 0; i < 4; i++) begin
      host.write(PE, (24'h1 << bits[i]) | 24'h1);
      host.write(SE, ~(24'h1 << bits[i]) & 24'hf00f01);
      lv[i] = 1'b1;
      cyc(3);
      pin(1'b0, 2'h1, 1'b1, "pri term on");
      pin(1'b1, 2'h1, 1'b0, "sec term off");
      sbit(bits[i], 1'b1, "status term");
      lv[i] = 1'b0;
      host.done(ST);
      cyc(3);
      pin(1'b0, 2'h1, 1'b0, "pri term gone");
    end
    $display("t_map done");
  endtask : t_map

  task automatic t_kinds;
    lv = 4'h1;
    for (int k = 0; k < 4; k++) begin
      host.write(PE, 24'h000100 | 24'(k));
      host.write(SE, 24'h000100 | 24'(k));
      cyc(3);
      pin(1'b0, 2'(k), 1'b1, "pri kind");
      pin(1'b1, 2'(k), 1'b1, "sec kind");
    end
    lv = 4'h0;
    host.done(ST);
    cyc(3);
    pin(1'b0, 2'h3, 1'b0, "pri released");
    $display("t_kinds done");
  endtask : t_kinds

  // Threshold field sits at 23..19; compare edges of the count
  task automatic t_fifo;
    host.write(MG, 24'h200004);
    fifo = 6'd4;
    sbit(23, 1'b0, "fill below");
    fifo = 6'd5;
    sbit(23, 1'b1, "fill at");
    host.done(ST);
    sbit(23, 1'b1, "fill held");
    fifo = 6'd4;
    sbit(23, 1'b0, "fill gone");
    host.write(MG, 24'hf80004);
    fifo = 6'd31;
    sbit(23, 1'b0, "fill 31");
    fifo = 6'd32;
    sbit(23, 1'b1, "fill 32");
    host.write(PE, 24'h800001);
    host.write(DY, 24'h8affff);
    rdchk(DY, 24'h8a0000, "dyn stored");
    chk({16'h0, qm, qt}, 24'h00008a, "dyn outputs");
    pin(1'b0, 2'h1, 1'b1, "fill kept");
    fifo = 6'd0;
    $display("t_fifo done");
  endtask : t_fifo

  task automatic t_qrec;
    qrec = 1'b1;
    sbit(21, 1'b1, "qrec set");
    host.done(ST);
    sbit(21, 1'b1, "qrec active");
    qrec = 1'b0;
    sbit(21, 1'b1, "qrec held");
    host.done(ST);
    sbit(21, 1'b0, "qrec cleared");
    host.write(MG, 24'hf80044);
    qrec = 1'b1;
    sbit(21, 1'b1, "qrec set 1");
    host.done(ST);
    sbit(21, 1'b0, "qrec read clr");
    cyc(4);
    sbit(21, 1'b0, "qrec no reset");
    qrec = 1'b0;
    cyc(2);
    qrec = 1'b1;
    sbit(21, 1'b1, "qrec reentry");
    qrec = 1'b0;
    host.done(ST);
    $display("t_qrec done");
  endtask : t_qrec

  // Wrong clear first, then the one the mode selects
  task automatic t_beat;
    logic [6:0] bad;
    logic [6:0] good;
    for (int m = 0; m < 3; m++) begin
      host.write(MG, 24'hf80004 | (24'(m) << 4));
      bad = (m == 0) ? ecgim_pkg::ADDR_BEAT_INTERVAL : ST;
      good = (m == 1) ? ecgim_pkg::ADDR_BEAT_INTERVAL : ST;
      pulse(1'b1);
      sbit(10, 1'b1, "beat set");
      host.done(bad);
      sbit(10, 1'b1, "beat kept");
      if (m == 2) pulse(1'b0);
      else host.done(good);
      sbit(10, 1'b0, "beat cleared");
    end
    $display("t_beat done");
  endtask : t_beat

  // Free-running decimation: any 16 instants hold 16/div ticks
  task automatic t_tick;
    logic [23:0] n;
    for (int r = 0; r < 4; r++) begin
      host.write(MG, 24'hf80000 | 24'(r));
      n = 24'h0;
      for (int i = 0; i < 16; i++) begin
        pulse(1'b0);
        host.read(ST, v);
        n = n + {23'h0, v[9]};
        host.done(ST);
      end
      chk(n, (r == 3) ? 24'd1 : (24'd16 >> r), "tick count");
    end
    host.write(MG, 24'hf80004);
    host.write(SE, 24'h000201);
    for (int i = 0; i < 4; i++) begin
      pulse(1'b0);
      cyc(39);
    end
    pulse(1'b0);
    cyc(3);
    pin(1'b1, 2'h1, 1'b1, "tick up");
    cyc(17);
    pin(1'b1, 2'h1, 1'b0, "tick self clr");
    $display("t_tick done");
  endtask : t_tick

  // ==========================================
  // Verdict and watchdog
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Whole run is about 720 cycles; allow 50000 cycles, about seventy times that
  initial begin
    #500000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    fifo = 6'd0;
    lv = 4'h0;
    qrec = 1'b0;
    beat = 1'b0;
    inst = 1'b0;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset();
    t_map();
    t_kinds();
    t_fifo();
    t_qrec();
    t_beat();
    t_tick();
    conclude();
  end
endmodule : ecgim_top_tb
